// ===== verilog/cfp_power_ctrl.sv
`timescale 1ns/1ns
module cfp_power_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_save_instr,
  input wire logic power_save_idle,
  input wire logic irq_pending,
  input wire logic watchdog_enable,
  input wire logic watchdog_timeout,
  input wire logic clock_switch_cfg_bit,
  input wire logic [2:0] default_osc,
  input wire logic sys_clk_edge,
  input wire logic low_power_rc_tick,
  output logic low_power_rc_osc_run,
  output logic sys_osc_run,
  output logic [2:0] osc_select,
  output logic pll_select,
  output logic clk_fail_trap,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic async_logic_en,
  output logic watchdog_clear,
  output logic resume_at_isr,
  output logic cpu_halted
);

  typedef enum logic [2:0] {
    ST_RUN,
    ST_ENTER,
    ST_SLEEP,
    ST_IDLE,
    ST_WAKE
  } cfp_state_t;

  cfp_state_t state;
  cfp_pkg::cfp_divider_t divider;
  logic [2:0] next_osc_select;
  logic pll_en;
  logic fail_flag;
  logic strap_done;
  logic target_idle;
  logic [1:0] wake_cnt;
  logic [1:0] miss_cnt;
  logic fail_event;
  logic mon_enable;
  logic mon_active;
  logic wake_event;
  logic doze_tick;
  logic apb_wr;
  logic apb_rd;
  logic [1:0] mode_code;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign pready = 1'b1;

  // Monitor and switching need the configuration bit programmed low
  assign mon_enable = !clock_switch_cfg_bit;
  assign mon_active = mon_enable && state != ST_SLEEP
    && osc_select != cfp_pkg::OSC_FAST_RC;
  assign wake_event = irq_pending || watchdog_timeout;

  // Clock divider register; an interrupt may end doze
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      divider.recover <= 1'b0;
      divider.ratio <= cfp_pkg::DOZE_RESET;
      divider.enable <= 1'b0;
    end
    else
    begin
      if (apb_wr && paddr == cfp_pkg::ADDR_DIVIDER)
      begin
        divider.recover <= pwdata[cfp_pkg::DIV_RECOVER_BIT];
        divider.ratio <= pwdata[cfp_pkg::DIV_DOZE_LSB +:
          cfp_pkg::DOZE_W];
        divider.enable <= pwdata[cfp_pkg::DIV_DOZE_EN_BIT];
      end
      if (divider.recover && divider.enable && irq_pending)
        divider.enable <= 1'b0;
    end
  end

  // Oscillator selection and PLL control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      next_osc_select <= cfp_pkg::OSC_FAST_RC;
      pll_en <= 1'b0;
    end
    else if (apb_wr && paddr == cfp_pkg::ADDR_OSCCTL && mon_enable)
    begin
      next_osc_select <= pwdata[cfp_pkg::OSC_NEXT_LSB +:
        cfp_pkg::OSC_W];
      pll_en <= pwdata[cfp_pkg::OSC_PLL_BIT];
    end
  end

  // Active source: strap after reset, then switches or fail-over
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_select <= cfp_pkg::OSC_FAST_RC;
      strap_done <= 1'b0;
    end
    else if (!strap_done)
    begin
      osc_select <= default_osc;
      strap_done <= 1'b1;
    end
    else if (fail_event)
      osc_select <= cfp_pkg::OSC_FAST_RC;
    else if (mon_enable && apb_wr && paddr == cfp_pkg::ADDR_OSCCTL)
      osc_select <= pwdata[cfp_pkg::OSC_NEXT_LSB +: cfp_pkg::OSC_W];
  end

  // PLL factor survives fail-over
  assign pll_select = pll_en;

  // Missing-edge counter on the low-power RC reference
  assign fail_event = mon_active && low_power_rc_tick && !sys_clk_edge
    && miss_cnt == cfp_pkg::FAIL_LAST;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      miss_cnt <= '0;
    else if (!mon_active || sys_clk_edge || fail_event)
      miss_cnt <= '0;
    else if (low_power_rc_tick)
      miss_cnt <= miss_cnt + 1'b1;
  end

  // Sticky failure flag, set beats write-one-to-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fail_flag <= 1'b0;
    else if (fail_event)
      fail_flag <= 1'b1;
    else if (apb_wr && paddr == cfp_pkg::ADDR_OSCCTL
      && pwdata[cfp_pkg::OSC_FAIL_BIT])
      fail_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_fail_trap <= 1'b0;
    else
      clk_fail_trap <= fail_event;
  end

  // Power-save sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_RUN;
      target_idle <= 1'b0;
      wake_cnt <= '0;
    end
    else
    begin
      unique case (state)
        ST_RUN:
          if (power_save_instr)
          begin
            state <= ST_ENTER;
            target_idle <= power_save_idle == cfp_pkg::PS_IDLE;
          end
        ST_ENTER:
          // Interrupts wait here until the mode is reached
          state <= target_idle ? ST_IDLE : ST_SLEEP;
        ST_SLEEP, ST_IDLE:
          if (wake_event)
          begin
            state <= ST_WAKE;
            wake_cnt <= cfp_pkg::WAKE_LOAD;
          end
        ST_WAKE:
          if (wake_cnt == '0)
            state <= ST_RUN;
          else
            wake_cnt <= wake_cnt - 1'b1;
      endcase
    end
  end

  // Resume point: handler when an interrupt woke the device
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      resume_at_isr <= 1'b0;
    else if ((state == ST_SLEEP || state == ST_IDLE) && wake_event)
      resume_at_isr <= irq_pending;
  end

  // Watchdog cleared as the mode is entered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watchdog_clear <= 1'b0;
    else
      watchdog_clear <= state == ST_RUN && power_save_instr;
  end

  cfp_doze_div #(
    .RATIO_W(cfp_pkg::DOZE_W)
  ) u_doze (
    .pclk(pclk),
    .presetn(presetn),
    .enable(divider.enable),
    .ratio(divider.ratio),
    .tick(doze_tick)
  );

  assign cpu_halted = state != ST_RUN;
  assign cpu_clk_en = state == ST_RUN && doze_tick;
  assign periph_clk_en = state != ST_SLEEP;
  assign sys_osc_run = state != ST_SLEEP;
  assign async_logic_en = 1'b1;
  assign low_power_rc_osc_run = (state == ST_SLEEP) ? watchdog_enable
    : (state == ST_IDLE) ? (watchdog_enable || mon_enable)
    : (mon_enable || watchdog_enable);

  always_comb
  begin
    unique case (state)
      ST_SLEEP: mode_code = cfp_pkg::MODE_SLEEP;
      ST_IDLE: mode_code = cfp_pkg::MODE_IDLE;
      ST_WAKE: mode_code = cfp_pkg::MODE_WAKE;
      default: mode_code = cfp_pkg::MODE_RUN;
    endcase
  end

  // Read data registered in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (apb_rd && !penable)
    begin
      prdata <= '0;
      unique case (paddr)
        cfp_pkg::ADDR_DIVIDER:
        begin
          prdata[cfp_pkg::DIV_RECOVER_BIT] <= divider.recover;
          prdata[cfp_pkg::DIV_DOZE_LSB +: cfp_pkg::DOZE_W]
            <= divider.ratio;
          prdata[cfp_pkg::DIV_DOZE_EN_BIT] <= divider.enable;
        end
        cfp_pkg::ADDR_OSCCTL:
        begin
          prdata[cfp_pkg::OSC_PLL_BIT] <= pll_en;
          prdata[cfp_pkg::OSC_NEXT_LSB +: cfp_pkg::OSC_W]
            <= next_osc_select;
          prdata[cfp_pkg::OSC_CUR_LSB +: cfp_pkg::OSC_W] <= osc_select;
          prdata[cfp_pkg::OSC_FAIL_BIT] <= fail_flag;
        end
        cfp_pkg::ADDR_PMSTAT:
        begin
          prdata[cfp_pkg::PM_MODE_LSB +: 2] <= mode_code;
          prdata[cfp_pkg::PM_DOZE_BIT] <= divider.enable;
        end
        default:
          prdata <= '0;
      endcase
    end
  end

  assign pslverr = psel && penable && paddr != cfp_pkg::ADDR_DIVIDER
    && paddr != cfp_pkg::ADDR_OSCCTL && paddr != cfp_pkg::ADDR_PMSTAT;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_fail_trap: assert property (fail_event |=> clk_fail_trap
    && osc_select == cfp_pkg::OSC_FAST_RC)
    else $error("fail-over did not reach fast RC");
  a_pll_kept: assert property (fail_event |=> $stable(pll_select))
    else $error("pll changed on fail-over");
  a_entry_only: assert property ($rose(cpu_halted)
    |-> $past(power_save_instr))
    else $error("halt without power-save instruction");
  a_sleep_off: assert property (state == ST_SLEEP
    |-> !sys_osc_run && !periph_clk_en && !cpu_clk_en)
    else $error("clocks running in sleep");
  a_mon_sleep: assert property (state == ST_SLEEP |-> !fail_event)
    else $error("monitor active in sleep");
  a_rc_sleep: assert property (state == ST_SLEEP
    |-> low_power_rc_osc_run == watchdog_enable)
    else $error("low-power RC wrong in sleep");
  a_watchdog_clear: assert property (state == ST_RUN && power_save_instr
    |=> watchdog_clear ##1 (state == ST_SLEEP || state == ST_IDLE))
    else $error("watchdog not cleared on entry");
  a_wake_soon: assert property ((state == ST_SLEEP
    || state == ST_IDLE) && wake_event |=> state == ST_WAKE)
    else $error("no wake on event");
  a_same_osc: assert property (state == ST_SLEEP && !apb_wr
    |=> $stable(osc_select))
    else $error("clock source moved in sleep");
  a_wake_delay: assert property ($rose(state == ST_WAKE)
    |-> !cpu_clk_en [*3] ##1 state == ST_RUN)
    else $error("cpu clock not back in time");
  a_defer_irq: assert property (state == ST_ENTER
    |=> state == ST_SLEEP || state == ST_IDLE)
    else $error("entry interrupted");
  a_rc_mon: assert property (state == ST_RUN && mon_enable
    |-> low_power_rc_osc_run)
    else $error("low-power RC off with monitor on");
  a_irq_exit: assert property (divider.recover && divider.enable
    && irq_pending && !apb_wr |=> !divider.enable)
    else $error("interrupt did not end doze");
  a_switch_lock: assert property (clock_switch_cfg_bit
    && strap_done |=> $stable(osc_select))
    else $error("source switched while locked");

  c_fail: cover property (fail_event ##1 clk_fail_trap);
  c_sleep_wake: cover property (state == ST_SLEEP ##1 state == ST_WAKE);
  c_idle_irq: cover property (state == ST_IDLE && irq_pending);
  c_doze: cover property (divider.enable && divider.ratio == 3'h7);

endmodule

// ===== verilog/cfp_pkg.sv
package cfp_pkg;

  // Register byte offsets
  localparam logic [11:0] ADDR_DIVIDER = 12'h000;
  localparam logic [11:0] ADDR_OSCCTL = 12'h004;
  localparam logic [11:0] ADDR_PMSTAT = 12'h008;

  // Clock divider register fields
  localparam int DIV_RECOVER_BIT = 15;
  localparam int DIV_DOZE_LSB = 12;
  localparam int DIV_DOZE_EN_BIT = 11;

  // Oscillator control register fields
  localparam int OSC_PLL_BIT = 11;
  localparam int OSC_NEXT_LSB = 8;
  localparam int OSC_CUR_LSB = 4;
  localparam int OSC_FAIL_BIT = 3;

  // Power-management status fields
  localparam int PM_MODE_LSB = 0;
  localparam int PM_DOZE_BIT = 2;

  localparam int DOZE_W = 3;
  localparam int OSC_W = 3;

  localparam logic [DOZE_W-1:0] DOZE_RESET = 3'h0;
  localparam logic [OSC_W-1:0] OSC_FAST_RC = 3'h0;

  // Power-save instruction operand
  localparam logic PS_SLEEP = 1'b0;
  localparam logic PS_IDLE = 1'b1;

  // Mode codes shown in the status register
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_WAKE = 2'h3;

  // Cycles from wake to first CPU clock, inside the 2-4 window
  localparam int WAKE_CYCLES = 3;
  localparam logic [1:0] WAKE_LOAD = 2'(WAKE_CYCLES - 1);

  // Reference ticks without a system clock edge before failure
  localparam int FAIL_TICKS = 2;
  localparam logic [1:0] FAIL_LAST = 2'(FAIL_TICKS - 1);

  typedef struct packed {
    logic recover;
    logic [DOZE_W-1:0] ratio;
    logic enable;
  } cfp_divider_t;

endpackage

// ===== verilog/cfp_doze_div.sv
`timescale 1ns/1ns
module cfp_doze_div #(
  parameter int RATIO_W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [RATIO_W-1:0] ratio,
  output logic tick
);

  localparam int CNT_W = (1 << RATIO_W) - 1;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] last;

  // Divisor is two to the power of the ratio field
  assign last = CNT_W'((1 << ratio) - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= '0;
    else if (!enable || cnt >= last)
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end

  assign tick = !enable || (cnt == '0);

endmodule

// ===== tb/cfp_osc_model.sv
`timescale 1ns/1ns
module cfp_osc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_osc_run,
  input wire logic low_power_rc_run,
  input wire logic [2:0] osc_sel,
  input wire logic fail,
  output logic sys_clk_edge,
  output logic low_power_rc_tick
);
  logic [1:0] div;

  // Reference ticks every fourth cycle while it runs
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      div <= 2'h0;
    else if (low_power_rc_run)
      div <= div + 2'h1;

  assign low_power_rc_tick = low_power_rc_run & (div == 2'h3);
  // A failed source goes quiet, fast RC keeps running
  assign sys_clk_edge = sys_osc_run & ~(fail & (osc_sel != 3'h0));
endmodule

// ===== tb/clock_fail_and_power_save_ctrl_test.sv
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    if ((g) !== (e)) \
      errors++; \
  end

module clock_fail_and_power_save_ctrl_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, power_save_instr = 1'b0, power_save_idle = 1'b0;
  logic irq_pending = 1'b0, watchdog_enable = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic clock_switch_cfg_bit = 1'b1, osc_fail = 1'b0, err;
  logic [2:0] default_osc = 3'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, sys_clk_edge, low_power_rc_tick;
  logic low_power_rc_osc_run, sys_osc_run, pll_select, clk_fail_trap;
  logic cpu_clk_en, periph_clk_en;
  logic async_logic_en, watchdog_clear, resume_at_isr, cpu_halted;
  logic [2:0] osc_select;
  int errors = 0, cmp_count = 0, n, h, p, t;

  always #10 pclk = ~pclk;

  cfp_power_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_save_instr(power_save_instr), .power_save_idle(power_save_idle),
    .irq_pending(irq_pending), .watchdog_enable(watchdog_enable),
    .watchdog_timeout(watchdog_timeout),
    .clock_switch_cfg_bit(clock_switch_cfg_bit),
    .default_osc(default_osc), .sys_clk_edge(sys_clk_edge),
    .low_power_rc_tick(low_power_rc_tick),
    .low_power_rc_osc_run(low_power_rc_osc_run),
    .sys_osc_run(sys_osc_run), .osc_select(osc_select),
    .pll_select(pll_select), .clk_fail_trap(clk_fail_trap),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .async_logic_en(async_logic_en), .watchdog_clear(watchdog_clear),
    .resume_at_isr(resume_at_isr), .cpu_halted(cpu_halted));

  cfp_osc_model u_osc (.pclk(pclk), .presetn(presetn),
    .sys_osc_run(sys_osc_run), .low_power_rc_run(low_power_rc_osc_run),
    .osc_sel(osc_select), .fail(osc_fail), .sys_clk_edge(sys_clk_edge),
    .low_power_rc_tick(low_power_rc_tick));

  task test_done;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task timeout;
    errors++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    test_done();
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task count_en(input int cyc);
    h = 0;
    p = 0;
    t = 0;
    repeat (cyc)
    begin
      @(posedge pclk);
      #1;
      h += int'(cpu_clk_en === 1'b1);
      p += int'(periph_clk_en === 1'b1);
      t += int'(clk_fail_trap === 1'b1);
    end
  endtask

  task wake_wait;
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (cpu_clk_en !== 1'b1 && n < 50);
    if (n >= 50)
      timeout();
  endtask

  task psave(input logic idle, input logic irq);
    @(posedge pclk);
    power_save_instr <= 1'b1;
    power_save_idle <= idle;
    irq_pending <= irq;
    @(posedge pclk);
    power_save_instr <= 1'b0;
    #1;
    `CHK(watchdog_clear, 1'b1)
    `CHK(cpu_halted, 1'b1)
  endtask

  task t_reset_regs;
    apb(1'b0, cfp_pkg::ADDR_DIVIDER, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, cfp_pkg::ADDR_OSCCTL, 32'h0);
    `CHK(rd[6:4], 3'h1)
    apb(1'b0, cfp_pkg::ADDR_PMSTAT, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(err, 1'b1)
    `CHK(pready, 1'b1)
    `CHK(rd, 32'h0)
    `CHK(low_power_rc_osc_run, 1'b0)
    `CHK(async_logic_en, 1'b1)
  endtask

  task t_switch_cfg;
    apb(1'b1, cfp_pkg::ADDR_OSCCTL, 32'h0000_0d00);
    `CHK(osc_select, 3'h1)
    `CHK(pll_select, 1'b0)
    @(posedge pclk);
    clock_switch_cfg_bit <= 1'b0;
    @(posedge pclk);
    #1;
    `CHK(low_power_rc_osc_run, 1'b1)
    apb(1'b1, cfp_pkg::ADDR_OSCCTL, 32'h0000_0a00);
    apb(1'b0, cfp_pkg::ADDR_OSCCTL, 32'h0);
    `CHK(rd, 32'h0000_0a20)
    `CHK(osc_select, 3'h2)
  endtask

  task t_doze;
    for (int r = 0; r < 8; r++)
    begin
      apb(1'b1, cfp_pkg::ADDR_DIVIDER, 32'h0800 | (r << 12));
      count_en(256);
      `CHK(h, 256 >> r)
      `CHK(p, 256)
    end
    apb(1'b0, cfp_pkg::ADDR_PMSTAT, 32'h0);
    `CHK(rd[2], 1'b1)
    apb(1'b1, cfp_pkg::ADDR_DIVIDER, 32'h0000_3800);
    @(posedge pclk);
    irq_pending <= 1'b1;
    count_en(64);
    `CHK(h, 8)
    apb(1'b1, cfp_pkg::ADDR_DIVIDER, 32'h0000_b800);
    apb(1'b0, cfp_pkg::ADDR_DIVIDER, 32'h0);
    `CHK(rd, 32'h0000_b000)
    count_en(64);
    `CHK(h, 64)
    @(posedge pclk);
    irq_pending <= 1'b0;
    apb(1'b1, cfp_pkg::ADDR_DIVIDER, 32'h0);
  endtask

  task t_idle;
    @(posedge pclk);
    watchdog_enable <= 1'b1;
    psave(1'b1, 1'b0);
    count_en(8);
    `CHK(h, 0)
    `CHK(p, 8)
    `CHK(sys_osc_run, 1'b1)
    `CHK(low_power_rc_osc_run, 1'b1)
    apb(1'b0, cfp_pkg::ADDR_PMSTAT, 32'h0);
    `CHK(rd[1:0], cfp_pkg::MODE_IDLE)
    @(posedge pclk);
    irq_pending <= 1'b1;
    wake_wait();
    `CHK(n, cfp_pkg::WAKE_CYCLES + 1)
    `CHK(resume_at_isr, 1'b1)
    @(posedge pclk);
    irq_pending <= 1'b0;
  endtask

  task t_defer;
    psave(1'b1, 1'b1);
    `CHK(cpu_clk_en, 1'b0)
    wake_wait();
    `CHK(n, cfp_pkg::WAKE_CYCLES + 2)
    `CHK(resume_at_isr, 1'b1)
    @(posedge pclk);
    irq_pending <= 1'b0;
  endtask

  task t_sleep;
    psave(1'b0, 1'b0);
    count_en(32);
    `CHK(h, 0)
    `CHK(p, 0)
    `CHK(t, 0)
    `CHK(sys_osc_run, 1'b0)
    `CHK(async_logic_en, 1'b1)
    `CHK(low_power_rc_osc_run, 1'b1)
    @(posedge pclk);
    watchdog_timeout <= 1'b1;
    wake_wait();
    `CHK(n, cfp_pkg::WAKE_CYCLES + 1)
    `CHK(resume_at_isr, 1'b0)
    `CHK(osc_select, 3'h2)
    @(posedge pclk);
    watchdog_timeout <= 1'b0;
  endtask

  task t_fail;
    @(posedge pclk);
    osc_fail <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (clk_fail_trap !== 1'b1 && n < 60);
    if (n >= 60)
      timeout();
    @(posedge pclk);
    #1;
    `CHK(clk_fail_trap, 1'b0)
    `CHK(osc_select, cfp_pkg::OSC_FAST_RC)
    `CHK(pll_select, 1'b1)
    apb(1'b0, cfp_pkg::ADDR_OSCCTL, 32'h0);
    `CHK(rd[3], 1'b1)
    @(posedge pclk);
    osc_fail <= 1'b0;
  endtask

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset_regs();
    t_switch_cfg();
    t_doze();
    t_idle();
    t_defer();
    t_sleep();
    t_fail();
    test_done();
  end
endmodule
